// [uvw_pkg.sv]
// constants for the commutation and incremental output block
// assumes one 10 MHz clock and a 14-bit shaft angle sampled on it
// How it works
// - recompute quadrature outputs at the update rate
// - quadrature edges never closer than one update
// - three hall-like commutation outputs are driven
// - each commutation output high half the cycle
// - outputs offset one hundred twenty electrical degrees from each other
// - revolution split into one cycle per pole pair
// - three-bit pole pair field in config register
// - code k gives 6(k+1) states per revolution
// - hysteresis on commutation transitions suppresses noise
package uvw_pkg;
	// ==========================================================
	// register map (printed offsets are word indices)
	localparam logic [7:0] CFG_INDEX = 8'h07; // pole pair configuration
	localparam logic [7:0] HYS_INDEX = 8'h08; // hysteresis width
	localparam logic [7:0] STAT_INDEX = 8'h09; // live state readback
	localparam logic [7:0] CFG_ADDR = 8'(CFG_INDEX * 4);
	localparam logic [7:0] HYS_ADDR = 8'(HYS_INDEX * 4);
	localparam logic [7:0] STAT_ADDR = 8'(STAT_INDEX * 4);
	// ==========================================================
	// field layout and reset values
	localparam int POLE_SEL_LSB = 0; // pole pair select low bit
	localparam int POLE_SEL_W = 3; // pole pair select width
	localparam logic [2:0] POLE_SEL_RESET = 3'h0; // one pole pair
	localparam logic [7:0] HYS_RESET = 8'h10; // electrical angle lsbs
	localparam int ST_UVW_LSB = 0; // commutation outputs
	localparam int ST_STEP_LSB = 3; // accepted step
	localparam int ST_RAW_LSB = 6; // unfiltered sector
	localparam int ST_QUAD_LSB = 9; // quadrature outputs
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// angle and step geometry
	localparam int ANGLE_W = 14; // shaft angle width
	localparam int QPOS_W = 12; // quadrature position width
	localparam logic [2:0] STEPS = 3'h6; // steps per electrical cycle
	// hall pattern per step, ordered {w,v,u}: one bit moves per step
	localparam logic [2:0] UVW_LUT [6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_PS = 100000; // 10 MHz ref_clk
	localparam int UPD_PERIOD_PS = 62500; // 16 MHz update rate
	localparam int UPD_CYCLES = (UPD_PERIOD_PS / CLK_PERIOD_PS) < 1 ? 1 : (UPD_PERIOD_PS / CLK_PERIOD_PS);
endpackage

// [uvw_sec_if.sv]
// carries one electrical angle into a sector decoder and its sector back
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface uvw_sec_if;
	logic [13:0] angle; // electrical angle
	logic [2:0] sector; // 0..5, sixty degree slice
	modport dec (input angle, output sector);
	modport user (output angle, input sector);
endinterface

// [uvw_sector.sv]
// maps an electrical angle onto one of six equal sectors
// assumes a full 14-bit turn of the angle is one electrical cycle
`timescale 1ns/1ps
module uvw_sector
(
	uvw_sec_if.dec sec
);
	// ==========================================================
	// sector = floor(angle * 6 / 2^14), always 0..5
	wire [16:0] scaled;
	assign scaled = {3'h0, sec.angle} * 17'h00006;
	assign sec.sector = scaled[16:14];
endmodule

// [uvw_top.sv]
// commutation outputs and quadrature outputs driven from a shaft angle
// assumes angle_in is synchronous to ref_clk; registers over AXI4-Lite
`timescale 1ns/1ps
module uvw_top
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [13:0] angle_in,
	output logic [2:0] commutation_outputs,
	output logic [2:0] incremental_quadrature_outputs,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==========================================================
	// state
	logic [2:0] pole_pair_select; // config field
	logic [7:0] hys_width; // hysteresis in electrical lsbs
	logic [3:0] upd_cnt; // update divider
	logic upd_en; // one-cycle update pulse
	logic [2:0] step; // accepted commutation step
	logic [11:0] qpos; // quadrature position
	logic aw_hold; // write address captured
	logic w_hold; // write data captured
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// ==========================================================
	// update divider: slower rates are one-cycle enables
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			upd_cnt <= 4'h0;
			upd_en <= 1'b0;
		end
		else if (upd_cnt == 4'(uvw_pkg::UPD_CYCLES - 1))
		begin
			// clock is slower than 16 MHz, so every cycle is an update
			upd_cnt <= 4'h0;
			upd_en <= 1'b1;
		end
		else
		begin
			upd_cnt <= upd_cnt + 4'h1;
			upd_en <= 1'b0;
		end
	end

	// ==========================================================
	// electrical angle: mechanical angle times pole pairs, wrapped
	wire [17:0] elec_full;
	wire [13:0] elec;
	wire [13:0] elec_lo;
	wire [13:0] elec_hi;
	assign elec_full = {4'h0, angle_in} * {14'h0000, 1'b0, pole_pair_select} + {4'h0, angle_in};
	assign elec = elec_full[13:0];
	assign elec_lo = elec - {6'h00, hys_width};
	assign elec_hi = elec + {6'h00, hys_width};

	// three decoders: the angle itself and both hysteresis edges
	uvw_sec_if sec_mid ();
	uvw_sec_if sec_lo ();
	uvw_sec_if sec_hi ();
	assign sec_mid.angle = elec;
	assign sec_lo.angle = elec_lo;
	assign sec_hi.angle = elec_hi;
	uvw_sector u_sec_mid (.sec(sec_mid));
	uvw_sector u_sec_lo (.sec(sec_lo));
	uvw_sector u_sec_hi (.sec(sec_hi));

	// ==========================================================
	// step decision: a new sector counts only once the whole
	// hysteresis band lies inside it
	wire settled;
	wire [2:0] target;
	wire [2:0] fwd_dist;
	wire go_fwd;
	wire [2:0] step_up;
	wire [2:0] step_dn;
	wire [2:0] next_step;
	assign settled = (sec_lo.sector == sec_hi.sector);
	assign target = sec_lo.sector;
	assign fwd_dist = (target >= step) ? (target - step) : (target + uvw_pkg::STEPS - step);
	assign go_fwd = (fwd_dist <= 3'h3);
	assign step_up = (step == uvw_pkg::STEPS - 3'h1) ? 3'h0 : step + 3'h1;
	assign step_dn = (step == 3'h0) ? uvw_pkg::STEPS - 3'h1 : step - 3'h1;
	// a large jump is walked one step per update, never skipped
	assign next_step = (!upd_en || !settled || target == step) ? step : (go_fwd ? step_up : step_dn);

	// commutation step and outputs
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			step <= 3'h0;
			commutation_outputs <= uvw_pkg::UVW_LUT[0];
		end
		else
		begin
			step <= next_step;
			commutation_outputs <= uvw_pkg::UVW_LUT[next_step];
		end
	end

	// ==========================================================
	// quadrature: position walks one count per update toward the angle
	wire [11:0] qtarget;
	wire [11:0] qdiff;
	wire [11:0] next_qpos;
	assign qtarget = angle_in[13:2];
	assign qdiff = qtarget - qpos;
	// one count per update keeps edges an update period apart
	assign next_qpos = (!upd_en || qdiff == 12'h000) ? qpos : (qdiff[11] ? qpos - 12'h001 : qpos + 12'h001);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			qpos <= 12'h000;
			incremental_quadrature_outputs <= 3'h4;
		end
		else
		begin
			qpos <= next_qpos;
			// {z,b,a}: a and b in quadrature, z at position zero
			incremental_quadrature_outputs <= {next_qpos == 12'h000, next_qpos[1], next_qpos[1] ^ next_qpos[0]};
		end
	end

	// ==========================================================
	// AXI4-Lite write channel: address and data taken in either order
	wire aw_take;
	wire w_take;
	wire wr_fire;
	wire wr_cfg;
	wire wr_hys;
	wire wr_known;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
	assign wr_cfg = wr_fire && aw_addr == uvw_pkg::CFG_ADDR && w_strb[0];
	assign wr_hys = wr_fire && aw_addr == uvw_pkg::HYS_ADDR && w_strb[0];
	assign wr_known = aw_addr == uvw_pkg::CFG_ADDR || aw_addr == uvw_pkg::HYS_ADDR || aw_addr == uvw_pkg::STAT_ADDR;

	// capture address and data, answer once both are in
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= uvw_pkg::RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_hold <= 1'b1;
				aw_addr <= {s_axi_awaddr[7:2], 2'h0};
				s_axi_awready <= 1'b0;
			end
			if (w_take)
			begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_known ? uvw_pkg::RESP_OKAY : uvw_pkg::RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				// reopen only after the response, one write at a time
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// software registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pole_pair_select <= uvw_pkg::POLE_SEL_RESET;
			hys_width <= uvw_pkg::HYS_RESET;
		end
		else
		begin
			if (wr_cfg)
				pole_pair_select <= w_data[uvw_pkg::POLE_SEL_LSB +: uvw_pkg::POLE_SEL_W];
			if (wr_hys)
				hys_width <= w_data[7:0];
		end
	end

	// ==========================================================
	// AXI4-Lite read channel: data one cycle after the address
	wire [7:0] rd_addr;
	wire [31:0] stat_word;
	wire [31:0] rd_word;
	wire rd_known;
	assign rd_addr = {s_axi_araddr[7:2], 2'h0};
	assign stat_word = {20'h00000, incremental_quadrature_outputs, sec_mid.sector, step, commutation_outputs};
	assign rd_known = rd_addr == uvw_pkg::CFG_ADDR || rd_addr == uvw_pkg::HYS_ADDR || rd_addr == uvw_pkg::STAT_ADDR;
	// reserved bits read as zero
	assign rd_word = (rd_addr == uvw_pkg::CFG_ADDR) ? {29'h00000000, pole_pair_select}
		: (rd_addr == uvw_pkg::HYS_ADDR) ? {24'h000000, hys_width}
		: (rd_addr == uvw_pkg::STAT_ADDR) ? stat_word : 32'h00000000;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= uvw_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_known ? uvw_pkg::RESP_OKAY : uvw_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// [uvw_top_props.sv]
// port-level checks of the commutation block
// assumes one clock ref_clk and synchronous active low rst_n
`timescale 1ns/1ps
module uvw_top_props
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [2:0] commutation_outputs,
	input wire logic [2:0] incremental_quadrature_outputs,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==========
	// clocking and handshake sequences
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
	sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
	// ==========
	// output and bus properties
	AST_ONE_BIT: assert property (!$stable(commutation_outputs) |->
		$countones(commutation_outputs ^ $past(commutation_outputs)) == 1) else $error("two hall bits moved");
	AST_HALL_LEGAL: assert property (commutation_outputs != 3'h0 && commutation_outputs != 3'h7)
		else $error("illegal hall code");
	// gray steps on a and b keep edges one update apart
	AST_QUAD_GRAY: assert property ($countones(incremental_quadrature_outputs[1:0] ^
		$past(incremental_quadrature_outputs[1:0])) <= 1) else $error("a and b moved together");
	AST_INDEX: assert property (incremental_quadrature_outputs[2] |->
		incremental_quadrature_outputs[1:0] == 2'h0) else $error("index off position zero");
	AST_B_HOLD: assert property (b_wait |=> s_axi_bvalid) else $error("bvalid dropped early");
	AST_R_HOLD: assert property (r_wait |=> s_axi_rvalid) else $error("rvalid dropped early");
	AST_AR_LOW: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
	AST_AW_LOW: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write overlap");
endmodule
bind uvw_top uvw_top_props u_uvw_top_props (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.commutation_outputs(commutation_outputs),
	.incremental_quadrature_outputs(incremental_quadrature_outputs),
	.s_axi_awready(s_axi_awready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

// [uvw_drive_model.sv]
// drive controller model that decodes the hall outputs into steps
// assumes it samples the outputs on ref_clk like a real drive
`timescale 1ns/1ps
module uvw_drive_model
(
	input wire logic ref_clk,
	input wire logic [2:0] hall,
	output int net_steps,
	output int toggles
);
	// ==========
	// step decode
	// hall code to step, the inverse of the block's step table
	int pos [8] = '{0, 1, 3, 2, 5, 0, 4, 0};
	logic [2:0] last = 3'h5; // hall code of the reset step 0
	int d;
	initial net_steps = 0;
	initial toggles = 0;
	// forward or backward neighbour counts one step
	always @(posedge ref_clk)
	begin
		// outputs are unknown until the first reset edge: ignore them
		if (!$isunknown(hall) && hall !== last)
		begin
			d = (pos[hall] - pos[last] + 6) % 6;
			net_steps = net_steps + (d == 1 ? 1 : (d == 5 ? -1 : 0));
			toggles = toggles + 1;
			last = hall;
		end
	end
endmodule

// [uvw_top_tb.sv]
// self-checking bench for the commutation block
// assumes AXI4-Lite at byte addresses from uvw_pkg
`timescale 1ns/1ps
module uvw_top_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [13:0] angle_in = 14'h0;
	logic [2:0] commutation_outputs, incremental_quadrature_outputs;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] lut [6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4}; // hall per step
	int fails = 0, cmp_count = 0, net_steps, toggles, s;
	always #50 ref_clk = ~ref_clk;
	uvw_top u_uvw_top (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.angle_in(angle_in),
		.commutation_outputs(commutation_outputs),
		.incremental_quadrature_outputs(incremental_quadrature_outputs),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);
	uvw_drive_model u_uvw_drive_model (.ref_clk(ref_clk), .hall(commutation_outputs), .net_steps(net_steps), .toggles(toggles));
	// ==========
	// helpers
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// each channel released at its own handshake
	task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(er), 32'(s_axi_bresp));
	endtask
	task rd(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", ev, s_axi_rdata);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
	endtask
	// one full shaft turn, slow enough for the filter
	task turn(input logic fwd);
		for (int i = 0; i < 1024; i++)
		begin
			@(posedge ref_clk);
			angle_in <= fwd ? angle_in + 14'h10 : angle_in - 14'h10;
			cyc(3);
		end
		cyc(20);
	endtask
	// ==========
	// scenarios
	task t_regs;
		chk("uvw", 32'h5, 32'(commutation_outputs));
		chk("quad", 32'h4, 32'(incremental_quadrature_outputs));
		rd(uvw_pkg::CFG_ADDR, 32'h0, uvw_pkg::RESP_OKAY);
		rd(uvw_pkg::HYS_ADDR, 32'h10, uvw_pkg::RESP_OKAY);
		rd(8'h30, 32'h0, uvw_pkg::RESP_SLVERR);
		wr(8'h30, 32'h7, uvw_pkg::RESP_SLVERR);
		wr(uvw_pkg::STAT_ADDR, 32'h0, uvw_pkg::RESP_OKAY);
		wr(uvw_pkg::CFG_ADDR, 32'h7, uvw_pkg::RESP_OKAY);
		rd(uvw_pkg::CFG_ADDR, 32'h7, uvw_pkg::RESP_OKAY);
		$display("test regs done");
	endtask
	// every code, steps counted by the drive model
	task t_poles;
		angle_in <= 14'h3FE0;
		cyc(20);
		for (int k = 0; k < 8; k++)
		begin
			wr(uvw_pkg::CFG_ADDR, 32'(k), uvw_pkg::RESP_OKAY);
			s = net_steps;
			turn(1'b1);
			chk("steps", 32'(6 * (k + 1)), 32'(net_steps - s));
		end
		wr(uvw_pkg::CFG_ADDR, 32'h1, uvw_pkg::RESP_OKAY);
		s = net_steps;
		turn(1'b0);
		chk("back", 32'(-12), 32'(net_steps - s));
		wr(uvw_pkg::CFG_ADDR, 32'h0, uvw_pkg::RESP_OKAY);
		$display("test poles done");
	endtask
	task t_table;
		for (int i = 0; i < 6; i++)
		begin
			angle_in <= 14'(i * 2731 + 1365);
			cyc(10);
			chk("uvw", 32'(lut[i]), 32'(commutation_outputs));
		end
		angle_in <= 14'h0;
		cyc(800);
		chk("quad", 32'h4, 32'(incremental_quadrature_outputs));
		angle_in <= 14'h4;
		cyc(3);
		chk("quad", 32'h1, 32'(incremental_quadrature_outputs));
		angle_in <= 14'h8;
		cyc(3);
		chk("quad", 32'h3, 32'(incremental_quadrature_outputs));
		$display("test table done");
	endtask
	// dither across the first boundary with and without band
	task dither;
		s = toggles;
		repeat (50)
		begin
			angle_in <= 14'd2721;
			cyc(2);
			angle_in <= 14'd2741;
			cyc(2);
		end
	endtask
	task t_hys;
		angle_in <= 14'd1365;
		cyc(10);
		dither();
		chk("quiet", 32'h0, 32'(toggles - s));
		wr(uvw_pkg::HYS_ADDR, 32'h0, uvw_pkg::RESP_OKAY);
		dither();
		chk("noisy", 32'h1, 32'(toggles > s));
		$display("test hys done");
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========
	// main sequence and watchdog
	initial
	begin
		cyc(5);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_poles();
		t_table();
		t_hys();
		finish_test();
	end
	initial
	begin
		#8000000;
		fails++;
		finish_test();
	end
endmodule
